// *** rtl/tecc_ctr.v ***
// one 32-bit event counter with threshold filter, wrap and interrupt
// assumes cfg held by the bus slave; event count raw, qualification arrives on gate_in
`timescale 1ns/1ps
`include "tecc_regs.vh"
module tecc_ctr (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire [31:0] cfg_in,
  input  wire [3:0]  ev_in,
  input  wire        gate_in,
  input  wire        partner_wrap_in,
  input  wire        ld_in,
  input  wire [31:0] ld_val_in,
  input  wire        wrap_clr_in,
  output reg  [31:0] cnt_out,
  output reg         wrap_flag_out,
  output wire        wrap_out,
  output reg  [1:0]  intr_out
);
  reg cmp_prev;
  reg armed;
  reg pend;
  wire cmp_res = cfg_in[`TECC_CMPL] ?
                 (ev_in <= cfg_in[`TECC_THR]) :
                 (ev_in > cfg_in[`TECC_THR]);
  wire hit = cfg_in[`TECC_EDGE] ? (cmp_res & ~cmp_prev) :
             cmp_res;
  wire [3:0] filt = cfg_in[`TECC_CMP] ? {3'h0, hit} : ev_in;
  wire run = ~cfg_in[`TECC_CASC] | armed;
  wire [3:0] inc = (cfg_in[`TECC_EN] & gate_in & run) ?
                   filt : 4'h0;
  wire [32:0] sum = {1'b0, cnt_out} + {29'h0, inc};
  wire any = (inc != 4'h0);
  assign wrap_out = any & (sum[32] | cfg_in[`TECC_FORCE]);
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt_out  <= `TECC_CNT_RST;
      wrap_flag_out <= 1'b0;
      intr_out <= 2'h0;
      cmp_prev <= 1'b0;
      armed    <= 1'b0;
      pend     <= 1'b0;
    end else begin
      cmp_prev <= cmp_res;
      if (ld_in)
        cnt_out <= ld_val_in;
      else if (any)
        cnt_out <= sum[31:0];
      // set beats a clear in the same cycle
      wrap_flag_out <= wrap_out | (wrap_flag_out & ~wrap_clr_in);
      armed <= cfg_in[`TECC_CASC] & cfg_in[`TECC_EN] &
               (armed | partner_wrap_in);
      // interrupt waits for the next count after the wrap
      intr_out <= (pend & any) ?
                  {cfg_in[`TECC_INT_T1], cfg_in[`TECC_INT_T0]} :
                  2'h0;
      pend <= wrap_out | (pend & ~any);
    end
  end
endmodule // tecc_ctr

// *** rtl/tecc_qual.v ***
// privilege and thread qualification of one selected event source
// assumes flags laid out as in the selector register, levels from cores
`timescale 1ns/1ps
`include "tecc_regs.vh"
module tecc_qual (
  input  wire [3:0] flags_in,
  input  wire [1:0] priv0_in,
  input  wire [1:0] priv1_in,
  input  wire       indep_in,
  input  wire       origin_id_in,
  output wire       ok_out
);
  wire k0 = (priv0_in == `TECC_PRIV_KERN);
  wire k1 = (priv1_in == `TECC_PRIV_KERN);
  wire t0 = (flags_in[`TECC_Q_T0_KERN] & k0) |
            (flags_in[`TECC_Q_T0_USER] & ~k0);
  wire t1 = (flags_in[`TECC_Q_T1_KERN] & k1) |
            (flags_in[`TECC_Q_T1_USER] & ~k1);
  wire mk = flags_in[`TECC_Q_T0_KERN] | flags_in[`TECC_Q_T1_KERN];
  wire mu = flags_in[`TECC_Q_T0_USER] | flags_in[`TECC_Q_T1_USER];
  // specific: only the originating thread's flags matter
  wire spec_ok = origin_id_in ? t1 : t0;
  // independent: union of both selections, either thread at level
  wire indep_ok = (mk & mu) |
                  (mk & (k0 | k1)) |
                  (mu & (~k0 | ~k1));
  assign ok_out = indep_in ? indep_ok : spec_ok;
endmodule // tecc_qual

// *** rtl/tecc_regs.vh ***
// register map, field positions and codes for the event counter pair
// assumes a 32-bit avalon-mm slave with byte addresses = 4 * index
`ifndef TECC_REGS_VH
`define TECC_REGS_VH
`define TECC_IDX_CFG0   10'h370
`define TECC_IDX_CFG1   10'h371
`define TECC_IDX_PSE    10'h372
`define TECC_IDX_CNT0   10'h373
`define TECC_IDX_CNT1   10'h374
`define TECC_IDX_QUAL   10'h375
`define TECC_CFG_RST    32'h00000000
`define TECC_CFG_WMASK  32'h4FFFF000
`define TECC_QUAL_RST   32'h00000000
`define TECC_CNT_RST    32'h00000000
`define TECC_EN         12
`define TECC_SEL        15:13
`define TECC_ACT        17:16
`define TECC_CMP        18
`define TECC_CMPL       19
`define TECC_THR        23:20
`define TECC_EDGE       24
`define TECC_FORCE      25
`define TECC_INT_T0     26
`define TECC_INT_T1     27
`define TECC_CASC       30
`define TECC_WRAP_FLAG  31
`define TECC_PSE_OWN    25
`define TECC_PSE_OTH    26
`define TECC_ACT_NONE   2'h0
`define TECC_ACT_SINGLE 2'h1
`define TECC_ACT_BOTH   2'h2
`define TECC_PRIV_KERN  2'h0
`define TECC_Q_T1_USER  0
`define TECC_Q_T1_KERN  1
`define TECC_Q_T0_USER  2
`define TECC_Q_T0_KERN  3
`endif

// *** rtl/tecc_top.v ***
// two thread-shared event counters with their configuration,
// qualification and an avalon-mm register slave
// assumes event sources, thread state, privilege level on clk_in
`timescale 1ns/1ps
`include "tecc_regs.vh"
module tecc_top (
  input  wire        clk_in,
  input  wire        rst_in,
  // register bus
  input  wire [11:0] avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // thread issuing the bus access
  input  wire        bus_thread_in,
  // eight event sources, four bits of count each
  input  wire [31:0] ev_cnt_in,
  input  wire [7:0]  ev_indep_in,
  input  wire [7:0]  ev_origin_id_in,
  input  wire [7:0]  ev_precise_class_in,
  // thread state
  input  wire [1:0]  halt_in,
  input  wire [1:0]  wait_startup_msg_in,
  input  wire [1:0]  priv_t0_in,
  input  wire [1:0]  priv_t1_in,
  // results
  output reg  [1:0]  perf_monitor_interrupt_out,
  output reg  [1:0]  precise_sample_out
);

  // bus handshake: every access takes two cycles
  reg         ack;
  wire        req;
  wire        wr;
  wire        word;
  wire [9:0]  idx;
  wire [31:0] bmask;

  assign req  = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack;
  assign wr   = avs_write_in & ack;
  assign word = (avs_address_in[1:0] == 2'h0);
  assign idx  = avs_address_in[11:2];
  assign bmask = {{8{avs_byteenable_in[3]}},
                  {8{avs_byteenable_in[2]}},
                  {8{avs_byteenable_in[1]}},
                  {8{avs_byteenable_in[0]}}};

  always @(posedge clk_in) begin
    if (rst_in)
      ack <= 1'b0;
    else
      ack <= req & ~ack;
  end

  // address decode
  wire hit_cfg0 = word & (idx == `TECC_IDX_CFG0);
  wire hit_cfg1 = word & (idx == `TECC_IDX_CFG1);
  wire hit_pse  = word & (idx == `TECC_IDX_PSE);
  wire hit_cnt0 = word & (idx == `TECC_IDX_CNT0);
  wire hit_cnt1 = word & (idx == `TECC_IDX_CNT1);
  wire hit_qual = word & (idx == `TECC_IDX_QUAL);
  wire [1:0] hit_cfg = {hit_cfg1, hit_cfg0};
  wire [1:0] hit_cnt = {hit_cnt1, hit_cnt0};

  // thread activity
  wire act0;
  wire act1;
  assign act0 = ~(halt_in[0] | wait_startup_msg_in[0]);
  assign act1 = ~(halt_in[1] | wait_startup_msg_in[1]);

  // software state
  wire [63:0] cfg_q;
  reg  [31:0] qual_q;
  reg  [1:0]  pse_en;

  // counter side
  wire [63:0] cnt;
  wire [1:0]  wflag;
  wire [1:0]  wrap;
  wire [3:0]  intr;
  wire [1:0]  prec_hit;

  // selector register, flags per source
  always @(posedge clk_in) begin
    if (rst_in)
      qual_q <= `TECC_QUAL_RST;
    else if (wr & hit_qual)
      qual_q <= (qual_q & ~bmask) | (avs_writedata_in & bmask);
  end

  // sampling enables stored per thread, not per writer
  wire [1:0] pse_next;
  assign pse_next = bus_thread_in ?
    {avs_writedata_in[`TECC_PSE_OWN],
     avs_writedata_in[`TECC_PSE_OTH]} :
    {avs_writedata_in[`TECC_PSE_OTH],
     avs_writedata_in[`TECC_PSE_OWN]};

  always @(posedge clk_in) begin
    if (rst_in)
      pse_en <= 2'h0;
    else if (wr & hit_pse & avs_byteenable_in[3])
      pse_en <= pse_next;
  end

  // per-counter logic
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_ctr
      wire [31:0] cfg;
      wire [2:0]  sel;
      wire [3:0]  ev;
      wire [3:0]  flags;
      wire        q_ok;
      reg         act_ok;
      reg  [31:0] cfg_r;
      wire [31:0] ld_val;
      wire        wflag_clr;

      // one register per counter keeps a single driver per bit
      assign cfg_q[k*32 +: 32] = cfg_r;
      assign cfg   = cfg_r;
      assign sel   = cfg[`TECC_SEL];
      assign ev    = ev_cnt_in[sel*4 +: 4];
      assign flags = qual_q[sel*4 +: 4];

      always @* begin
        case (cfg[`TECC_ACT])
          `TECC_ACT_NONE:   act_ok = ~act0 & ~act1;
          `TECC_ACT_SINGLE: act_ok = act0 ^ act1;
          `TECC_ACT_BOTH:   act_ok = act0 & act1;
          default:          act_ok = act0 | act1;
        endcase
      end

      // configuration: reserved bits never stored
      always @(posedge clk_in) begin
        if (rst_in)
          cfg_r <= `TECC_CFG_RST;
        else if (wr & hit_cfg[k])
          cfg_r <=
            (cfg & ~(bmask & `TECC_CFG_WMASK)) |
            (avs_writedata_in & bmask & `TECC_CFG_WMASK);
      end

      // writing zero to the sticky bit clears it
      assign wflag_clr = wr & hit_cfg[k] & avs_byteenable_in[3] &
                         ~avs_writedata_in[`TECC_WRAP_FLAG];

      assign ld_val = (cnt[k*32 +: 32] & ~bmask) |
                      (avs_writedata_in & bmask);

      tecc_qual u_qual (
        .flags_in     (flags),
        .priv0_in     (priv_t0_in),
        .priv1_in     (priv_t1_in),
        .indep_in     (ev_indep_in[sel]),
        .origin_id_in (ev_origin_id_in[sel]),
        .ok_out       (q_ok)
      );

      tecc_ctr u_ctr (
        .clk_in          (clk_in),
        .rst_in          (rst_in),
        .cfg_in          (cfg),
        .ev_in           (ev),
        .gate_in         (act_ok & q_ok),
        .partner_wrap_in (wrap[1-k]),
        .ld_in           (wr & hit_cnt[k]),
        .ld_val_in       (ld_val),
        .wrap_clr_in     (wflag_clr),
        .cnt_out         (cnt[k*32 +: 32]),
        .wrap_flag_out   (wflag[k]),
        .wrap_out        (wrap[k]),
        .intr_out        (intr[k*2 +: 2])
      );

      // counter k serves thread k alone for sampling
      assign prec_hit[k] = wrap[k] & pse_en[k] &
                           ev_precise_class_in[sel];
    end
  endgenerate

  // thread interrupts registered once more, sampling requests registered once
  always @(posedge clk_in) begin
    if (rst_in) begin
      perf_monitor_interrupt_out <= 2'h0;
      precise_sample_out         <= 2'h0;
    end else begin
      perf_monitor_interrupt_out <= intr[1:0] | intr[3:2];
      precise_sample_out         <= prec_hit;
    end
  end

  // read data, loaded on the first cycle of a read
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (hit_cfg0)
      rd_mux = {wflag[0], cfg_q[30:0]};
    else if (hit_cfg1)
      rd_mux = {wflag[1], cfg_q[62:32]};
    else if (hit_cnt0)
      rd_mux = cnt[31:0];
    else if (hit_cnt1)
      rd_mux = cnt[63:32];
    else if (hit_qual)
      rd_mux = qual_q;
    else if (hit_pse) begin
      rd_mux[`TECC_PSE_OWN] = pse_en[bus_thread_in];
      rd_mux[`TECC_PSE_OTH] = pse_en[~bus_thread_in];
    end
  end

  always @(posedge clk_in) begin
    if (rst_in)
      avs_readdata_out <= 32'h00000000;
    else if (avs_read_in & ~ack)
      avs_readdata_out <= rd_mux;
  end

endmodule // tecc_top

// *** sim/tecc_props.sv ***
// checker on the tecc_top ports: reset, bus timing, read-back masks
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module tecc_props (
  input wire        clk_in,
  input wire        rst_in,
  input wire [11:0] avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire [7:0]  ev_precise_class_in,
  input wire [1:0]  perf_monitor_interrupt_out,
  input wire [1:0]  precise_sample_out
);
  wire       rd_ack = avs_read_in && !avs_waitrequest_out;
  wire [9:0] idx    = avs_address_in[11:2];
  wire       cfg_a  = (idx == 10'h370 || idx == 10'h371);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rst_out;
    $fell(rst_in) |-> (perf_monitor_interrupt_out == 2'h0 &&
      precise_sample_out == 2'h0) [*3];
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("pulse after reset");
  property p_rst_rd;
    $fell(rst_in) |-> avs_readdata_out == 32'h00000000;
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("readdata not cleared");
  property p_rd_wait;
    $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_wait;
    $rose(avs_write_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait wrong");
  property p_idle;
    !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out;
  endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_rd_hold;
    !avs_read_in |=> $stable(avs_readdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
  property p_cfg_rsv;
    rd_ack && cfg_a && avs_address_in[1:0] == 2'h0 |->
      (avs_readdata_out & 32'h30000FFF) == 32'h00000000;
  endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("cfg spare set");
  property p_pse_rsv;
    rd_ack && avs_address_in == 12'hDC8 |->
      (avs_readdata_out & 32'hF9FFFFFF) == 32'h00000000;
  endproperty
  a_pse_rsv: assert property (p_pse_rsv) else $error("pse spare set");
  property p_pse_class;
    precise_sample_out != 2'h0 |-> $past(ev_precise_class_in, 1) != 8'h00;
  endproperty
  a_pse_class: assert property (p_pse_class) else $error("sample class");
  c_intr0: cover property (perf_monitor_interrupt_out[0]);
  c_intr1: cover property (perf_monitor_interrupt_out[1]);
  c_smp0: cover property (precise_sample_out[0]);
  c_unmap: cover property (rd_ack && idx > 10'h375);
endmodule // tecc_props
bind tecc_top tecc_props tecc_props_inst (
  .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .ev_precise_class_in(ev_precise_class_in),
  .perf_monitor_interrupt_out(perf_monitor_interrupt_out),
  .precise_sample_out(precise_sample_out));

// *** sim/tecc_src.sv ***
// event source and interrupt sink standing in for the two cores
// assumes pulses from the block last one cycle each
`timescale 1ns/1ps
module tecc_src (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire [3:0]  nib_in,
  input  wire [2:0]  src_in,
  input  wire [1:0]  intr_in,
  input  wire [1:0]  smp_in,
  output wire [31:0] ev_cnt_out
);
  reg [7:0] n_intr0;
  reg [7:0] n_intr1;
  reg [7:0] n_smp0;
  reg [7:0] n_smp1;
  // only one source carries events, so a wrong select shows up
  assign ev_cnt_out = {28'h0, nib_in} << {src_in, 2'h0};
  always @(posedge clk_in) begin
    if (rst_in) begin
      n_intr0 <= 8'h00;
      n_intr1 <= 8'h00;
      n_smp0  <= 8'h00;
      n_smp1  <= 8'h00;
    end else begin
      n_intr0 <= n_intr0 + {7'h0, intr_in[0]};
      n_intr1 <= n_intr1 + {7'h0, intr_in[1]};
      n_smp0  <= n_smp0 + {7'h0, smp_in[0]};
      n_smp1  <= n_smp1 + {7'h0, smp_in[1]};
    end
  end
endmodule // tecc_src

// *** sim/tecc_top_tb.sv ***
// bench for tecc_top: avalon-mm tasks and counting scenarios
// assumes tecc_src as event source and interrupt sink
`timescale 1ns/1ps
`include "tecc_regs.vh"
module tecc_top_tb;
  localparam [11:0] A_CFG0 = {`TECC_IDX_CFG0, 2'h0};
  localparam [11:0] A_PSE  = {`TECC_IDX_PSE, 2'h0};
  localparam [11:0] A_CNT0 = {`TECC_IDX_CNT0, 2'h0};
  localparam [11:0] A_CFG1 = {`TECC_IDX_CFG1, 2'h0};
  localparam [11:0] A_CNT1 = {`TECC_IDX_CNT1, 2'h0};
  localparam [11:0] A_QUAL = {`TECC_IDX_QUAL, 2'h0};
  localparam [31:0] E      = 32'h00031000;
  reg        clk_in, rst_in, rd, wr, bt;
  reg [11:0] ad;
  reg [31:0] wd, q;
  reg [7:0]  ind, org, cls;
  reg [1:0]  hlt, wsm, c0, c1;
  reg [3:0]  nib;
  reg [2:0]  src;
  wire [31:0] rdat, ev;
  wire        wq;
  wire [1:0]  intr, smp;
  integer     failures, tests_run;
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  tecc_top tecc_top_inst (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(ad), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .bus_thread_in(bt),
    .ev_cnt_in(ev), .ev_indep_in(ind), .ev_origin_id_in(org),
    .ev_precise_class_in(cls), .halt_in(hlt), .wait_startup_msg_in(wsm),
    .priv_t0_in(c0), .priv_t1_in(c1), .perf_monitor_interrupt_out(intr),
    .precise_sample_out(smp));
  tecc_src tecc_src_inst (.clk_in(clk_in), .rst_in(rst_in), .nib_in(nib),
    .src_in(src), .intr_in(intr), .smp_in(smp), .ev_cnt_out(ev));
  task complete_run;
    $display("tests %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge clk_in);
    ad <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_in);
    while (wq !== 1'b0) @(posedge clk_in);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rc(input string n, input [11:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task burst(input [3:0] v, input integer k);
    @(posedge clk_in);
    nib <= v;
    repeat (k) @(posedge clk_in);
    nib <= 4'h0;
    repeat (4) @(posedge clk_in);
  endtask
  task run(input string n, input [31:0] c, input [3:0] v, input integer k,
           input [31:0] e);
    bus(1'b1, A_CNT0, 32'h0);
    bus(1'b1, A_CFG0, c);
    burst(v, k);
    rc(n, A_CNT0, e);
  endtask
  task t_reset;
    rc("cfg0", A_CFG0, 32'h0);
    rc("pse", A_PSE, 32'h0);
    rc("unmapped", 12'hDD8, 32'h0);
    $display("t_reset done");
  endtask
  task t_count;
    bus(1'b1, A_QUAL, 32'hFFFFFFFF);
    run("count", E, 4'h2, 5, 32'hA);
    src <= 3'h1;
    run("other src", E, 4'h2, 5, 32'h0);
    run("sel src", E | 32'h2000, 4'h2, 5, 32'hA);
    run("disabled", 32'h00032000, 4'h2, 5, 32'h0);
    src <= 3'h0;
    run("above", E | 32'h00240000, 4'h3, 4, 32'h4);
    run("not above", E | 32'h00240000, 4'h2, 4, 32'h0);
    run("edge", E | 32'h01240000, 4'h3, 4, 32'h1);
    run("no cmp", E | 32'h01200000, 4'h3, 4, 32'hC);
    $display("t_count done");
  endtask
  task t_thread;
    hlt <= 2'h3;
    run("none", 32'h00001000, 4'h1, 3, 32'h3);
    hlt <= 2'h1;
    run("both", 32'h00021000, 4'h1, 3, 32'h0);
    run("single", 32'h00011000, 4'h1, 3, 32'h3);
    hlt <= 2'h0;
    wsm <= 2'h2;
    run("single wait", 32'h00011000, 4'h1, 3, 32'h3);
    wsm <= 2'h0;
    bus(1'b1, A_QUAL, 32'h4);
    c0 <= 2'h1;
    run("t0 user", E, 4'h1, 3, 32'h3);
    c0 <= 2'h0;
    run("t0 kern", E, 4'h1, 3, 32'h0);
    c1 <= 2'h2;
    bus(1'b1, A_QUAL, 32'h5);
    run("t1 flags", E, 4'h1, 3, 32'h0);
    org <= 8'h01;
    run("origin t1", E, 4'h1, 3, 32'h3);
    org <= 8'h00;
    ind <= 8'h01;
    run("indep", E, 4'h1, 3, 32'h3);
    ind <= 8'h00;
    c1 <= 2'h0;
    $display("t_thread done");
  endtask
  task t_wrap;
    cls <= 8'h01;
    // all flags on so the wrap counts whatever the privilege level
    bus(1'b1, A_QUAL, 32'hFFFFFFFF);
    bus(1'b1, A_PSE, 32'h02000000);
    rc("pse own", A_PSE, 32'h02000000);
    bt <= 1'b1;
    rc("pse other", A_PSE, 32'h04000000);
    bt <= 1'b0;
    bus(1'b1, A_CNT0, 32'hFFFFFFFF);
    bus(1'b1, A_CFG0, E | 32'h04000000);
    burst(4'h1, 1);
    rc("sticky", A_CFG0, E | 32'h84000000);
    chk("early intr", 32'h0, tecc_src_inst.n_intr0);
    chk("sample", 32'h1, tecc_src_inst.n_smp0);
    burst(4'h1, 1);
    chk("intr t0", 32'h1, tecc_src_inst.n_intr0);
    chk("intr t1 off", 32'h0, tecc_src_inst.n_intr1);
    bus(1'b1, A_CFG0, E);
    rc("cleared", A_CFG0, E);
    $display("t_wrap done");
  endtask
  task t_casc;
    bus(1'b1, A_PSE, 32'h04000000);
    bus(1'b1, A_CNT0, 32'hFFFFFFFF);
    bus(1'b1, A_CNT1, 32'h0);
    bus(1'b1, A_CFG1, E | 32'h48000000);
    burst(4'h1, 1);
    rc("casc wait", A_CNT1, 32'h0);
    burst(4'h1, 3);
    rc("casc run", A_CNT1, 32'h3);
    bus(1'b1, A_CFG1, E | 32'h4A000000);
    burst(4'h1, 2);
    chk("intr t1", 32'h1, tecc_src_inst.n_intr1);
    chk("intr t0 off", 32'h1, tecc_src_inst.n_intr0);
    chk("sample t1", 32'h2, tecc_src_inst.n_smp1);
    chk("no sample t0", 32'h1, tecc_src_inst.n_smp0);
    rc("sticky1", A_CFG1, E | 32'hCA000000);
    $display("t_casc done");
  endtask
  initial begin
    {rd, wr, bt, ad, wd, ind, org, cls} = 0;
    {hlt, wsm, c0, c1, nib, src} = 0;
    failures = 0;
    tests_run = 0;
    rst_in = 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_count;
    t_thread;
    t_wrap;
    t_casc;
    complete_run;
  end
  // about ten times the expected run length
  initial begin
    #400000;
    failures = failures + 1;
    complete_run;
  end
endmodule // tecc_top_tb
